// ---- logic/ncd_nvm_dispatch.sv ----
// Command dispatch, access checks and error flag of the memory controller
//
// Functional notes
// [RULE1] Region bit one selects secondary region
// [RULE2] Unpermitted secondary read clears both data bytes
// [RULE3] User IDs writable; device and config read-only
// [RULE4] Data EEPROM range is read and write
// [RULE5] Trigger on protected address sets error flag
// [RULE6] Reset during self-timed write sets error
// [RULE7] Broken unlock sequence sets error flag
// [RULE8] Error flag cleared only by software write
// [RULE9] Erase-select erases the whole addressed row
// [RULE10] Protected erase or program: abort, flag error
// [RULE11] Latch-only copies data pair into latch
// [RULE12] Row program uses latches, then blanks them
// [RULE13] Software verifies row contents after programming
// [RULE14] Software writes both keys before trigger
// [RULE15] Operations self-timed; trigger cleared at end
// [RULE16] EEPROM read loads only the low byte
// [RULE17] Non-writable secondary target treated as protected
module ncd_nvm_dispatch (
	// Clock and resets
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        por_n_i,
	// Software register port
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	// Memory array
	output logic             arr_start_o,
	output logic      [1:0]  arr_op_o,
	output logic      [15:0] arr_addr_o,
	output logic      [13:0] arr_wdata_o,
	output logic             arr_word_vld_o,
	output logic      [4:0]  arr_word_idx_o,
	input  wire logic [13:0] arr_rdata_i,
	input  wire logic        arr_done_i,
	input  wire logic        wp_i
);

	// Software registers
	logic [7:0]  data_low_byte_reg;
	logic [5:0]  data_high_byte_reg;
	logic [7:0]  addr_low_byte_reg;
	logic [6:0]  addr_high_byte_reg;
	logic        region_select_reg;
	logic        latch_only_reg;
	logic        erase_sel_reg;
	logic        write_en_reg;
	logic        wr_busy_reg;
	logic        rd_busy_reg;
	logic        write_error_flag_reg;
	logic        low_only_reg;
	// Sequencer
	ncd_pkg::ncd_state_type st_reg;
	ncd_pkg::ncd_state_type st_next;
	logic [4:0]  cnt_reg;
	logic        stream_vld_reg;
	logic [4:0]  stream_idx_reg;
	// Reset-abort tracking
	logic        rst_meta_reg;
	logic        rst_sync_reg;
	logic        in_prog_reg;
	logic        err_next;
	logic [13:0] mem_rdata;

	// Address and access decode
	wire [15:0] full_addr  = {region_select_reg, addr_high_byte_reg,
		addr_low_byte_reg};
	wire in_uid  = full_addr >= ncd_pkg::UID_LO && full_addr <= ncd_pkg::UID_HI;
	wire in_dev  = full_addr >= ncd_pkg::DEV_LO && full_addr <= ncd_pkg::DEV_HI;
	wire in_cfg  = full_addr >= ncd_pkg::CFG_LO && full_addr <= ncd_pkg::CFG_HI;
	wire in_ee   = full_addr >= ncd_pkg::EE_LO && full_addr <= ncd_pkg::EE_HI;
	wire sec_rd_ok = in_uid | in_dev | in_cfg | in_ee; // [RULE3] [RULE4]
	wire sec_wr_ok = in_uid | in_ee;                   // [RULE3] [RULE4]

	// Register strobes
	wire ctrl_wr = reg_wr_i && reg_addr_i == ncd_pkg::OFF_CTRL;
	wire key_wr  = reg_wr_i && reg_addr_i == ncd_pkg::OFF_KEY;
	wire idle    = (st_reg == ncd_pkg::ST_IDLE);
	wire armed;
	wire unlock_broken;
	wire wr_req  = ctrl_wr && reg_wdata_i[ncd_pkg::BIT_WR];

	// Trigger and action decode
	wire trig    = wr_req && armed && write_en_reg && idle; // [RULE14]
	wire rd_trig = ctrl_wr && reg_wdata_i[ncd_pkg::BIT_RD] && idle && !trig;
	wire flash_prot = (erase_sel_reg || !latch_only_reg) && wp_i;
	wire trig_fail = trig && (region_select_reg ? !sec_wr_ok   // [RULE17]
		: flash_prot);                                    // [RULE5] [RULE10]
	wire latch_copy = trig && !region_select_reg && !erase_sel_reg
		&& latch_only_reg;                                  // [RULE11]
	wire wr_launch = trig && !trig_fail && !latch_copy;
	wire rd_zero   = rd_trig && region_select_reg && !sec_rd_ok; // [RULE2]
	wire rd_launch = rd_trig && !rd_zero;
	wire op_done   = (st_reg == ncd_pkg::ST_WAIT) && arr_done_i;
	wire prog_start = wr_launch && !region_select_reg && !erase_sel_reg;
	wire [1:0] launch_op = rd_launch ? 2'(ncd_pkg::OP_READ)
		: region_select_reg ? 2'(ncd_pkg::OP_WORD_WRITE)         // [RULE1]
		: erase_sel_reg ? 2'(ncd_pkg::OP_ERASE)                  // [RULE9]
		: 2'(ncd_pkg::OP_ROW_PROG);                              // [RULE12]
	wire rd_done   = op_done && arr_op_o == 2'(ncd_pkg::OP_READ);
	wire latch_clr = op_done && (arr_op_o == 2'(ncd_pkg::OP_ROW_PROG)
		|| arr_op_o == 2'(ncd_pkg::OP_ERASE));                  // [RULE12]
	wire reset_abort = !rst_sync_reg && in_prog_reg;           // [RULE6]
	wire hw_err_set = trig_fail || unlock_broken || reset_abort; // [RULE7]

	// Unlock sequence tracker
	ncd_unlock u_unlock (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.any_wr_i  (reg_wr_i),
		.key_wr_i  (key_wr),
		.wdata_i   (reg_wdata_i),
		.trig_wr_i (wr_req),
		.armed_o   (armed),
		.broken_o  (unlock_broken)
	);

	// Write latch row
	ncd_latch_mem u_latch (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.wr_en_i   (latch_copy),
		.wr_idx_i  (addr_low_byte_reg[4:0]),
		.wr_data_i ({data_high_byte_reg, data_low_byte_reg}),
		.clr_i     (latch_clr),
		.rd_idx_i  (cnt_reg),
		.rd_data_o (mem_rdata)
	);

	// Sequencer next state
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ncd_pkg::ST_IDLE: begin
				if (prog_start) begin
					st_next = ncd_pkg::ST_STREAM;
				end else if (wr_launch || rd_launch) begin
					st_next = ncd_pkg::ST_WAIT;
				end
			end
			ncd_pkg::ST_STREAM: begin
				if (cnt_reg == ncd_pkg::IDX_LAST) begin
					st_next = ncd_pkg::ST_WAIT;
				end
			end
			ncd_pkg::ST_WAIT: begin
				if (arr_done_i) begin
					st_next = ncd_pkg::ST_IDLE; // [RULE15]
				end
			end
			default: begin
				st_next = ncd_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer, latch streaming and array outputs
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg         <= ncd_pkg::ST_IDLE;
			cnt_reg        <= 5'h00;
			stream_vld_reg <= 1'b0;
			stream_idx_reg <= 5'h00;
			arr_start_o    <= 1'b0;
			arr_op_o       <= 2'(ncd_pkg::OP_READ);
			arr_addr_o     <= 16'h0000;
			arr_wdata_o    <= ncd_pkg::LATCH_BLANK;
			arr_word_vld_o <= 1'b0;
			arr_word_idx_o <= 5'h00;
		end else begin
			st_reg         <= st_next;
			cnt_reg        <= (st_reg == ncd_pkg::ST_STREAM) ? cnt_reg + 5'h01
				: 5'h00;
			stream_vld_reg <= (st_reg == ncd_pkg::ST_STREAM);
			stream_idx_reg <= cnt_reg;
			arr_start_o    <= wr_launch || rd_launch;
			arr_word_vld_o <= stream_vld_reg;
			arr_word_idx_o <= stream_idx_reg;
			if (wr_launch || rd_launch) begin
				arr_op_o    <= launch_op;
				arr_addr_o  <= full_addr; // [RULE1]
				arr_wdata_o <= {data_high_byte_reg, data_low_byte_reg};
			end else if (stream_vld_reg) begin
				arr_wdata_o <= mem_rdata; // [RULE12]
			end
		end
	end

	// Control bits, busy bits and software registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			region_select_reg  <= 1'b0;
			latch_only_reg     <= 1'b0;
			erase_sel_reg      <= 1'b0;
			write_en_reg       <= 1'b0;
			wr_busy_reg        <= 1'b0;
			rd_busy_reg        <= 1'b0;
			low_only_reg       <= 1'b0;
			addr_low_byte_reg  <= ncd_pkg::ADDR_LO_RST;
			addr_high_byte_reg <= ncd_pkg::ADDR_HI_RST;
		end else begin
			if (ctrl_wr) begin
				region_select_reg <= reg_wdata_i[ncd_pkg::BIT_REGION];
				latch_only_reg    <= reg_wdata_i[ncd_pkg::BIT_LATCH];
				erase_sel_reg     <= reg_wdata_i[ncd_pkg::BIT_ERASE];
				write_en_reg      <= reg_wdata_i[ncd_pkg::BIT_WREN];
			end
			if (op_done && arr_op_o == 2'(ncd_pkg::OP_ERASE)) begin
				erase_sel_reg <= 1'b0;
			end
			if (wr_launch) begin
				wr_busy_reg <= 1'b1;
			end else if (op_done) begin
				wr_busy_reg <= 1'b0; // [RULE15]
			end
			if (rd_launch) begin
				rd_busy_reg  <= 1'b1;
				low_only_reg <= region_select_reg && in_ee;
			end else if (op_done) begin
				rd_busy_reg <= 1'b0;
			end
			if (reg_wr_i && reg_addr_i == ncd_pkg::OFF_ADDR_LO && idle) begin
				addr_low_byte_reg <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == ncd_pkg::OFF_ADDR_HI && idle) begin
				addr_high_byte_reg <= reg_wdata_i[6:0];
			end
		end
	end

	// Data pair: array read result wins over software
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_low_byte_reg  <= ncd_pkg::DATA_LO_RST;
			data_high_byte_reg <= ncd_pkg::DATA_HI_RST;
		end else if (rd_zero) begin
			data_low_byte_reg  <= 8'h00; // [RULE2]
			data_high_byte_reg <= 6'h00; // [RULE2]
		end else if (rd_done) begin
			data_low_byte_reg <= arr_rdata_i[7:0];
			if (!low_only_reg) begin
				data_high_byte_reg <= arr_rdata_i[13:8]; // [RULE16]
			end
		end else if (reg_wr_i) begin
			if (reg_addr_i == ncd_pkg::OFF_DATA_LO) begin
				data_low_byte_reg <= reg_wdata_i;
			end
			if (reg_addr_i == ncd_pkg::OFF_DATA_HI) begin
				data_high_byte_reg <= reg_wdata_i[5:0];
			end
		end
	end

	// Error flag: hardware set beats software write
	always_comb begin
		err_next = write_error_flag_reg;
		if (ctrl_wr) begin
			err_next = reg_wdata_i[ncd_pkg::BIT_ERR]; // [RULE8]
		end
		if (hw_err_set) begin
			err_next = 1'b1; // [RULE5] [RULE7] [RULE17]
		end
	end

	// Power-on domain: reset seen through two flops, abort tracking
	always_ff @(posedge clk_sys_i or negedge por_n_i) begin
		if (!por_n_i) begin
			rst_meta_reg         <= 1'b0;
			rst_sync_reg         <= 1'b0;
			in_prog_reg          <= 1'b0;
			write_error_flag_reg <= 1'b0;
		end else begin
			rst_meta_reg         <= rst_n_i;
			rst_sync_reg         <= rst_meta_reg;
			write_error_flag_reg <= err_next; // [RULE8]
			if (!rst_sync_reg) begin
				in_prog_reg <= 1'b0; // [RULE6]
			end else if (wr_launch) begin
				in_prog_reg <= 1'b1;
			end else if (op_done) begin
				in_prog_reg <= 1'b0;
			end
		end
	end

	// Read-back mux; data stands one cycle after the strobe
	wire [7:0] ctrl_view = {1'b0, region_select_reg, latch_only_reg,
		erase_sel_reg, write_error_flag_reg, write_en_reg, wr_busy_reg,
		rd_busy_reg};
	wire [7:0] rd_mux =
		(reg_addr_i == ncd_pkg::OFF_DATA_LO) ? data_low_byte_reg
		: (reg_addr_i == ncd_pkg::OFF_DATA_HI) ? {2'b00, data_high_byte_reg}
		: (reg_addr_i == ncd_pkg::OFF_ADDR_LO) ? addr_low_byte_reg
		: (reg_addr_i == ncd_pkg::OFF_ADDR_HI)
			? {ncd_pkg::ADDR_HI_PAD, addr_high_byte_reg}
		: (reg_addr_i == ncd_pkg::OFF_CTRL) ? ctrl_view
		: 8'h00;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_region;
		(wr_launch && region_select_reg) |=> arr_start_o && arr_addr_o[15];
	endproperty
	a_region: assert property (p_region) else $error("region bit lost"); // [RULE1]

	property p_zero_read;
		rd_zero |=> data_low_byte_reg == 8'h00 && data_high_byte_reg == 6'h00
			&& !arr_start_o;
	endproperty
	a_zero_read: assert property (p_zero_read) else $error("bad zero read"); // [RULE2]

	property p_ro_sec;
		(trig && region_select_reg && (in_dev || in_cfg))
			|=> write_error_flag_reg && !arr_start_o && !wr_busy_reg;
	endproperty
	a_ro_sec: assert property (p_ro_sec) else $error("read-only written"); // [RULE3]

	property p_ee_write;
		(trig && region_select_reg && in_ee) |=> arr_start_o
			&& arr_op_o == 2'(ncd_pkg::OP_WORD_WRITE) && wr_busy_reg;
	endproperty
	a_ee_write: assert property (p_ee_write) else $error("eeprom write lost"); // [RULE4]

	property p_wp;
		(trig && !region_select_reg && !latch_only_reg && wp_i)
			|=> write_error_flag_reg && !wr_busy_reg && !arr_start_o;
	endproperty
	a_wp: assert property (p_wp) else $error("protected op ran"); // [RULE10]

	property p_unlock;
		unlock_broken |=> write_error_flag_reg;
	endproperty
	a_unlock: assert property (p_unlock) else $error("no unlock error"); // [RULE7]

	property p_err_hold;
		@(posedge clk_sys_i) disable iff (!por_n_i)
		$fell(write_error_flag_reg) |-> $past(ctrl_wr)
			&& !$past(reg_wdata_i[ncd_pkg::BIT_ERR]);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("flag fell"); // [RULE8]

	property p_erase;
		(trig && !region_select_reg && erase_sel_reg && !wp_i)
			|=> arr_start_o && arr_op_o == 2'(ncd_pkg::OP_ERASE)
			##1 !arr_word_vld_o[*3];
	endproperty
	a_erase: assert property (p_erase) else $error("erase not issued"); // [RULE9]

	property p_latch;
		latch_copy |=> !arr_start_o && !wr_busy_reg && idle;
	endproperty
	a_latch: assert property (p_latch) else $error("latch copy hit array"); // [RULE11]

	property p_stream;
		prog_start |=> arr_op_o == 2'(ncd_pkg::OP_ROW_PROG)
			##2 arr_word_vld_o[*8];
	endproperty
	a_stream: assert property (p_stream) else $error("row not streamed"); // [RULE12]

	property p_done;
		op_done |=> !wr_busy_reg && !rd_busy_reg && idle;
	endproperty
	a_done: assert property (p_done) else $error("trigger not cleared"); // [RULE15]

	property p_ee_read;
		(rd_done && low_only_reg && !reg_wr_i) |=> $stable(data_high_byte_reg);
	endproperty
	a_ee_read: assert property (p_ee_read) else $error("high byte changed"); // [RULE16]

endmodule : ncd_nvm_dispatch

// ---- logic/ncd_pkg.sv ----
// Shared constants and types of the memory command dispatcher
package ncd_pkg;

	// Register offsets on the software port
	localparam logic [2:0] OFF_DATA_LO = 3'h0;
	localparam logic [2:0] OFF_DATA_HI = 3'h1;
	localparam logic [2:0] OFF_ADDR_LO = 3'h2;
	localparam logic [2:0] OFF_ADDR_HI = 3'h3;
	localparam logic [2:0] OFF_CTRL    = 3'h4;
	localparam logic [2:0] OFF_KEY     = 3'h5;

	// Bit positions inside memory_control_reg
	localparam int BIT_RD     = 0;
	localparam int BIT_WR     = 1;
	localparam int BIT_WREN   = 2;
	localparam int BIT_ERR    = 3;
	localparam int BIT_ERASE  = 4;
	localparam int BIT_LATCH  = 5;
	localparam int BIT_REGION = 6;

	// Reset values and fixed read-back bits
	localparam logic [7:0] ADDR_LO_RST = 8'h00;
	localparam logic [6:0] ADDR_HI_RST = 7'h00;
	localparam logic [7:0] DATA_LO_RST = 8'h00;
	localparam logic [5:0] DATA_HI_RST = 6'h00;
	localparam logic       ADDR_HI_PAD = 1'b1;

	// Unlock key pair
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Write latch row
	localparam int          ROW_WORDS   = 32;
	localparam int          IDX_W       = 5;
	localparam int          WORD_W      = 14;
	localparam logic [4:0]  IDX_LAST    = 5'h1f;
	localparam logic [13:0] LATCH_BLANK = 14'h3fff;

	// Secondary region windows (region bit on top)
	localparam logic [15:0] UID_LO = 16'h8000;
	localparam logic [15:0] UID_HI = 16'h8003;
	localparam logic [15:0] DEV_LO = 16'h8005;
	localparam logic [15:0] DEV_HI = 16'h8006;
	localparam logic [15:0] CFG_LO = 16'h8007;
	localparam logic [15:0] CFG_HI = 16'h800b;
	localparam logic [15:0] EE_LO  = 16'hf000;
	localparam logic [15:0] EE_HI  = 16'hf0ff;

	// Operations offered to the array
	typedef enum logic [1:0] {
		OP_READ       = 2'h0,
		OP_ERASE      = 2'h1,
		OP_ROW_PROG   = 2'h2,
		OP_WORD_WRITE = 2'h3
	} ncd_op_type;

	// Dispatcher sequence
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_STREAM = 2'b01,
		ST_WAIT   = 2'b11
	} ncd_state_type;

	// Unlock tracker
	typedef enum logic [1:0] {
		ULK_IDLE  = 2'b00,
		ULK_HALF  = 2'b01,
		ULK_ARMED = 2'b11
	} ncd_ulk_type;

endpackage : ncd_pkg

// ---- logic/ncd_latch_mem.sv ----
// Row of write latches with registered read port and bulk clear
module ncd_latch_mem (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// Write port
	input  wire logic        wr_en_i,
	input  wire logic [4:0]  wr_idx_i,
	input  wire logic [13:0] wr_data_i,
	input  wire logic        clr_i,
	// Read port
	input  wire logic [4:0]  rd_idx_i,
	output logic      [13:0] rd_data_o
);

	logic [13:0] word_reg [ncd_pkg::ROW_WORDS];

	// One latch per entry; clear returns all to blank
	for (genvar g = 0; g < ncd_pkg::ROW_WORDS; g++) begin : g_word
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				word_reg[g] <= ncd_pkg::LATCH_BLANK;
			end else if (clr_i) begin
				word_reg[g] <= ncd_pkg::LATCH_BLANK;
			end else if (wr_en_i && wr_idx_i == 5'(g)) begin
				word_reg[g] <= wr_data_i;
			end
		end
	end

	// Registered read
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= ncd_pkg::LATCH_BLANK;
		end else begin
			rd_data_o <= word_reg[rd_idx_i];
		end
	end

endmodule : ncd_latch_mem

// ---- logic/ncd_unlock.sv ----
// Tracks the two-key unlock sequence ahead of a write trigger
module ncd_unlock (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// Observed register writes
	input  wire logic       any_wr_i,
	input  wire logic       key_wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       trig_wr_i,
	// Status
	output logic            armed_o,
	output logic            broken_o
);

	ncd_pkg::ncd_ulk_type st_reg;
	ncd_pkg::ncd_ulk_type st_next;

	// After the first key, any write other than the expected one breaks the sequence
	always_comb begin
		st_next  = st_reg;
		broken_o = 1'b0;
		if (any_wr_i) begin
			case (st_reg)
				ncd_pkg::ULK_IDLE: begin
					if (key_wr_i && wdata_i == ncd_pkg::KEY_FIRST) begin
						st_next = ncd_pkg::ULK_HALF;
					end
				end
				ncd_pkg::ULK_HALF: begin
					if (key_wr_i && wdata_i == ncd_pkg::KEY_SECOND) begin
						st_next = ncd_pkg::ULK_ARMED;
					end else begin
						st_next  = ncd_pkg::ULK_IDLE;
						broken_o = 1'b1;
					end
				end
				ncd_pkg::ULK_ARMED: begin
					st_next  = ncd_pkg::ULK_IDLE;
					broken_o = !trig_wr_i;
				end
				default: begin
					st_next = ncd_pkg::ULK_IDLE;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= ncd_pkg::ULK_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign armed_o = (st_reg == ncd_pkg::ULK_ARMED);

endmodule : ncd_unlock

// ---- testbench/ncd_array_model.sv ----
// Behavioural flash and EEPROM array answering the dispatcher
module ncd_array_model (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// Requests from the dispatcher
	input  wire logic        start_i,
	input  wire logic [1:0]  op_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [13:0] wdata_i,
	input  wire logic        word_vld_i,
	input  wire logic [4:0]  word_idx_i,
	// Answer delay in cycles, one or more
	input  wire logic [7:0]  dly_i,
	// Answers
	output logic      [13:0] rdata_o,
	output logic             done_o,
	output logic      [15:0] starts_o
);
	logic [13:0] mem [logic [15:0]];
	logic [15:0] adr_reg;
	logic [1:0]  op_reg;
	logic [13:0] wd_reg;
	logic [7:0]  cnt_reg;
	logic [5:0]  words_reg;
	logic        busy_reg;

	// Unwritten cells read as erased
	function automatic logic [13:0] rd_word(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : 14'h3fff;
	endfunction : rd_word

	// Self-timed operation, done pulses once the work is over
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg <= 1'b0;
			done_o   <= 1'b0;
			rdata_o  <= 14'h2d2d;
			starts_o <= 16'h0000;
		end else begin
			done_o  <= 1'b0;
			rdata_o <= ~rdata_o; // Toggles while not valid
			if (start_i) begin
				busy_reg  <= 1'b1;
				op_reg    <= op_i;
				adr_reg   <= addr_i;
				wd_reg    <= wdata_i;
				cnt_reg   <= dly_i;
				words_reg <= 6'h00;
				starts_o  <= starts_o + 16'h0001;
			end else if (busy_reg) begin
				if (word_vld_i) begin
					mem[{adr_reg[15:5], word_idx_i}] = wdata_i;
					words_reg <= words_reg + 6'h01;
				end
				if (op_reg != ncd_pkg::OP_ROW_PROG || words_reg == 6'h20) begin
					cnt_reg <= cnt_reg - 8'h01;
					if (cnt_reg <= 8'h01) begin
						busy_reg <= 1'b0;
						done_o   <= 1'b1;
						if (op_reg == ncd_pkg::OP_READ)
							rdata_o <= rd_word(adr_reg);
						if (op_reg == ncd_pkg::OP_WORD_WRITE)
							mem[adr_reg] = wd_reg;
						if (op_reg == ncd_pkg::OP_ERASE)
							for (int i = 0; i < 32; i++)
								mem[{adr_reg[15:5], 5'(i)}] = 14'h3fff;
					end
				end
			end
		end
	end
endmodule : ncd_array_model

// ---- testbench/ncd_nvm_dispatch_tb.sv ----
// Self-checking bench for the memory command dispatcher
module ncd_nvm_dispatch_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// Register offsets and control bits
	localparam logic [2:0] A_DLO = ncd_pkg::OFF_DATA_LO;
	localparam logic [2:0] A_DHI = ncd_pkg::OFF_DATA_HI;
	localparam logic [2:0] A_CTL = ncd_pkg::OFF_CTRL;
	localparam logic [2:0] A_KEY = ncd_pkg::OFF_KEY;
	localparam logic [7:0] C_RD  = 8'h01 << ncd_pkg::BIT_RD;
	localparam logic [7:0] C_WR  = 8'h01 << ncd_pkg::BIT_WR;
	localparam logic [7:0] C_EN  = 8'h01 << ncd_pkg::BIT_WREN;
	localparam logic [7:0] C_ERR = 8'h01 << ncd_pkg::BIT_ERR;
	localparam logic [7:0] C_ER  = 8'h01 << ncd_pkg::BIT_ERASE;
	localparam logic [7:0] C_LAT = 8'h01 << ncd_pkg::BIT_LATCH;
	localparam logic [7:0] C_REG = 8'h01 << ncd_pkg::BIT_REGION;
	localparam logic [15:0] RTAB [10] = '{16'h0005, 16'h8000, 16'h8003,
		16'h8004, 16'h8005, 16'h800b, 16'h800c, 16'hf000, 16'hf0ff, 16'hf100};
	localparam logic [15:0] WTAB [5] = '{16'h8001, 16'hf010, 16'h8004,
		16'h8006, 16'h800b};

	logic        clk_sys_i;
	logic        rst_n_i;
	logic        por_n_i;
	logic [2:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic        arr_start_o;
	logic [1:0]  arr_op_o;
	logic [15:0] arr_addr_o;
	logic [13:0] arr_wdata_o;
	logic        arr_word_vld_o;
	logic [4:0]  arr_word_idx_o;
	logic [13:0] arr_rdata_i;
	logic        arr_done_i;
	logic        wp_i;
	logic [7:0]  dly;
	logic [15:0] starts;
	logic [15:0] s;
	logic [15:0] a;
	logic [13:0] e;
	logic        ok;
	int          checked;
	int          mismatches;

	// Device under test and array partner
	ncd_nvm_dispatch u_ncd_nvm_dispatch (.clk_sys_i, .rst_n_i, .por_n_i,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.arr_start_o, .arr_op_o, .arr_addr_o, .arr_wdata_o, .arr_word_vld_o,
		.arr_word_idx_o, .arr_rdata_i, .arr_done_i, .wp_i);
	ncd_array_model u_ncd_array_model (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .start_i(arr_start_o), .op_i(arr_op_o),
		.addr_i(arr_addr_o), .wdata_i(arr_wdata_o), .word_vld_i(arr_word_vld_o),
		.word_idx_i(arr_word_idx_o), .dly_i(dly), .rdata_o(arr_rdata_i),
		.done_o(arr_done_i), .starts_o(starts));

	// Clock of 100 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// Stored pattern and read class of an address
	function automatic logic [13:0] pat(input logic [15:0] x);
		return x[13:0] ^ (x[15] ? 14'h1a5c : 14'h0c3a);
	endfunction : pat
	function automatic int kind(input logic [15:0] x);
		if (!x[15]) return 1;
		if (x inside {[16'hf000:16'hf0ff]}) return 2;
		if (x inside {[16'h8000:16'h8003], [16'h8005:16'h800b]}) return 1;
		return 0;
	endfunction : kind
	function automatic logic [15:0] mw(input logic [15:0] x);
		return {2'b00, u_ncd_array_model.mem[x]};
	endfunction : mw

	// Register port cycles
	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= ad;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] ad, output logic [7:0] d);
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= ad;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		d = reg_rdata_o;
	endtask : rd

	// Comparisons
	task automatic chk8(input logic [7:0] g, input logic [7:0] x);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk8
	task automatic chk16(input logic [15:0] g, input logic [15:0] x);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk16
	task automatic rdchk(input logic [2:0] ad, input logic [7:0] x);
		logic [7:0] g;
		rd(ad, g);
		chk8(g, x);
	endtask : rdchk

	// Address, data pair, keyed trigger and bounded busy poll
	task automatic setadr(input logic [15:0] x);
		wr(ncd_pkg::OFF_ADDR_HI, {1'b0, x[14:8]});
		wr(ncd_pkg::OFF_ADDR_LO, x[7:0]);
	endtask : setadr
	task automatic setdat(input logic [13:0] w);
		wr(A_DLO, w[7:0]);
		wr(A_DHI, {2'b00, w[13:8]});
	endtask : setdat
	task automatic trig(input logic [7:0] c);
		wr(A_CTL, c);
		wr(A_KEY, ncd_pkg::KEY_FIRST);
		wr(A_KEY, ncd_pkg::KEY_SECOND);
		wr(A_CTL, c | C_WR);
	endtask : trig
	task automatic wait_idle();
		logic [7:0] v;
		for (int i = 0; i < 100; i++) begin
			rd(A_CTL, v);
			if (v[1:0] === 2'b00) return;
		end
		mismatches++;
		$display("BAD t=%0t got=%h exp=%h", $time, v, 8'h00);
		summarize();
	endtask : wait_idle

	// Verdict and end of run
	task automatic summarize();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		mismatches++;
		$display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
		summarize();
	end

	// Main sequence
	initial begin
		{rst_n_i, por_n_i, reg_wr_i, reg_rd_i, wp_i} = '0;
		reg_addr_i  = 3'h0;
		reg_wdata_i = 8'h00;
		dly         = 8'h01;
		checked     = 0;
		mismatches  = 0;
		foreach (RTAB[i]) u_ncd_array_model.mem[RTAB[i]] = pat(RTAB[i]);
		foreach (WTAB[i]) u_ncd_array_model.mem[WTAB[i]] = pat(WTAB[i]);
		for (int i = 0; i < 3; i++) u_ncd_array_model.mem[16'h0065 + 16'(i * 26)] = 14'h0123;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		por_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) rdchk(3'(i), i == 3 ? 8'h80 : 8'h00);
		$display("test reset done");
		// Two latches loaded, then row program, read back, second program
		s = starts;
		setadr(16'h0040);
		setdat(14'h1234);
		trig(C_EN | C_LAT);
		setadr(16'h005f);
		setdat(14'h2bcd);
		trig(C_EN | C_LAT);
		chk16(starts, s);
		dly <= 8'h0c;
		trig(C_EN);
		wait_idle();
		rdchk(A_CTL, C_EN);
		chk16(mw(16'h0040), 16'h1234);
		chk16(mw(16'h005f), 16'h2bcd);
		chk16(mw(16'h0041), 16'h3fff);
		wr(A_CTL, C_RD);
		wait_idle();
		rdchk(A_DLO, 8'hcd);
		rdchk(A_DHI, 8'h2b);
		trig(C_EN);
		wait_idle();
		chk16(mw(16'h0040), 16'h3fff);
		$display("test program done");
		// Row erase with latch-only set and data pair loaded
		setadr(16'h0065);
		trig(C_EN | C_ER | C_LAT);
		wait_idle();
		rdchk(A_CTL, C_EN | C_LAT);
		chk16(mw(16'h0065), 16'h3fff);
		chk16(mw(16'h007f), 16'h3fff);
		chk16(mw(16'h0099), 16'h0123);
		$display("test erase done");
		// Protected flash: program and erase refused, latch copy allowed
		@(posedge clk_sys_i) wp_i <= 1'b1;
		s = starts;
		trig(C_EN);
		rdchk(A_CTL, C_EN | C_ERR);
		wr(A_CTL, C_EN);
		rdchk(A_CTL, C_EN);
		trig(C_EN | C_ER);
		rdchk(A_CTL, C_EN | C_ER | C_ERR);
		chk16(starts, s);
		trig(C_EN | C_LAT);
		rdchk(A_CTL, C_EN | C_LAT);
		@(posedge clk_sys_i) wp_i <= 1'b0;
		$display("test protect done");
		// Error flag set by software survives a read; broken unlock sets it again
		wr(A_CTL, C_ERR);
		wr(A_CTL, C_ERR | C_RD);
		wait_idle();
		rdchk(A_CTL, C_ERR);
		wr(A_CTL, 8'h00);
		wr(A_KEY, ncd_pkg::KEY_FIRST);
		setadr(16'h0000);
		rdchk(A_CTL, C_ERR);
		$display("test flag done");
		// Flash and secondary region reads
		foreach (RTAB[i]) begin
			a = RTAB[i];
			e = kind(a) == 0 ? 14'h0000 : pat(a);
			setdat(14'h2a55);
			setadr(a);
			wr(A_CTL, a[15] ? C_REG : 8'h00);
			wr(A_CTL, (a[15] ? C_REG : 8'h00) | C_RD);
			wait_idle();
			rdchk(A_DLO, e[7:0]);
			rdchk(A_DHI, kind(a) == 2 ? 8'h2a : {2'b00, e[13:8]});
		end
		// Secondary region writes
		foreach (WTAB[i]) begin
			a = WTAB[i];
			ok = a inside {[16'h8000:16'h8003], [16'hf000:16'hf0ff]};
			setadr(a);
			setdat(14'h0abc);
			trig(C_REG | C_EN);
			wait_idle();
			chk16(mw(a), ok ? 16'h0abc : {2'b00, pat(a)});
			rdchk(A_CTL, C_REG | C_EN | (ok ? 8'h00 : C_ERR));
		end
		$display("test region done");
		// Reset while a slow erase is running
		dly <= 8'h1e;
		setadr(16'h0100);
		trig(C_EN | C_ER);
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rdchk(A_CTL, C_ERR);
		$display("test reset abort done");
		summarize();
	end
endmodule : ncd_nvm_dispatch_tb
